// File: i2c_stat_pkg.sv
// Constants shared by the I2C status and address-mask block.
// Assumes a 32-bit AXI4-Lite register bus and one peripheral clock.
package i2c_stat_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SLV_ADDR_W = 10;
    localparam int BYTE_W = 8;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFS_BUS_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_ADDR_MASK = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_RX_BYTE = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_TX_BYTE = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h18;

    // Field positions in the bus status register.
    localparam int BIT_TX_FULL = 0;
    localparam int BIT_RX_FULL = 1;
    localparam int BIT_DIR = 2;
    localparam int BIT_START = 3;
    localparam int BIT_OVERRUN = 6;

    // Interrupt event bits.
    localparam int IRQ_W = 5;
    localparam int EV_START = 0;
    localparam int EV_STOP = 1;
    localparam int EV_RX = 2;
    localparam int EV_TX_DONE = 3;
    localparam int EV_OVERRUN = 4;

    localparam logic [SLV_ADDR_W-1:0] MASK_RESET = 10'h000;
    localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 5'h00;
    localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SEL_STATUS,
        SEL_MASK,
        SEL_RX_BYTE,
        SEL_TX_BYTE,
        SEL_IRQ_STATUS,
        SEL_IRQ_CLEAR,
        SEL_IRQ_ENABLE,
        SEL_NONE
    } reg_sel_type;

endpackage

// File: addr_cmp_if.sv
// Carries the slave address comparison between the status block and
// the address matcher.  Assumes both ends share the peripheral clock.
`timescale 1ns/100ps
interface addr_cmp_if
    import i2c_stat_pkg::*;
();
    logic [SLV_ADDR_W-1:0] own_addr;
    logic [SLV_ADDR_W-1:0] rx_addr;
    logic [SLV_ADDR_W-1:0] mask;
    logic match;

    modport ctl (output own_addr, output rx_addr, output mask, input match);
    modport cmp (input own_addr, input rx_addr, input mask, output match);
endinterface

// File: addr_match.sv
// Masked slave address comparator with a registered match output.
// Assumes the address inputs are stable, synchronous to the clock.
`timescale 1ns/100ps
module addr_match
    import i2c_stat_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    addr_cmp_if.cmp cmp
);

    logic [SLV_ADDR_W-1:0] bit_ok;
    logic match_q;

    ////////////////////////////////////////////////////////////////////
    genvar g;
    generate
        for (g = 0; g < SLV_ADDR_W; g++)
        begin : g_bit
            // A masked position always agrees; others must be equal.
            assign bit_ok[g] = cmp.mask[g] |
                (cmp.rx_addr[g] == cmp.own_addr[g]);
        end
    endgenerate

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
            match_q <= 1'b0;
        else
            match_q <= &bit_ok;
    end

    assign cmp.match = match_q;

    ////////////////////////////////////////////////////////////////////
    chk_masked_match: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (((cmp.rx_addr ^ cmp.own_addr) & ~cmp.mask) == '0)
        |=> cmp.match)
        else $error("Masked address did not match.");

    chk_strict_miss: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (((cmp.rx_addr ^ cmp.own_addr) & ~cmp.mask) != '0)
        |=> !cmp.match)
        else $error("Unmasked bit mismatch still matched.");

endmodule

// File: i2c_stat_mask.sv
// Status flags and slave address mask of the I2C unit, on AXI4-Lite.
// Assumes bus-condition and byte events arrive as one-cycle pulses
// synchronous to i_ref_clk from the rest of the I2C unit.
//
// How it works
// - Start flag sets on start or repeated start, clears on stop.
// - Slave direction flag loads after an address byte; 1 read, 0 write.
// - Receive-full flag sets when a received byte is stored.
// - Software reading the receive byte register clears receive-full.
// - Software writing the transmit byte register sets transmit-full.
// - Transmit-full clears once the byte has been shifted out.
// - Address bits with mask bit one are ignored in matching.
// - Address bits with mask bit zero must match exactly.
// - Mask bits above nine read zero; all mask bits reset to zero.
// - Overrun flag sets when a byte arrives while receive-full.
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
module i2c_stat_mask
    import i2c_stat_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [ADDR_W-1:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [ADDR_W-1:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [DATA_W-1:0] o_rdata,
    output logic [1:0] o_rresp,
    input wire logic i_start_det,
    input wire logic i_stop_det,
    input wire logic i_addr_done,
    input wire logic i_addr_rw,
    input wire logic i_rx_valid,
    input wire logic [BYTE_W-1:0] i_rx_byte,
    input wire logic i_tx_done,
    input wire logic [SLV_ADDR_W-1:0] i_own_addr,
    input wire logic [SLV_ADDR_W-1:0] i_rx_addr,
    output logic o_addr_match,
    output logic [BYTE_W-1:0] o_tx_byte,
    output logic o_tx_load,
    output logic o_irq
);

    function automatic reg_sel_type decode(input logic [ADDR_W-1:0] a);
        unique case (a)
            OFS_BUS_STATUS: decode = SEL_STATUS;
            OFS_ADDR_MASK: decode = SEL_MASK;
            OFS_RX_BYTE: decode = SEL_RX_BYTE;
            OFS_TX_BYTE: decode = SEL_TX_BYTE;
            OFS_IRQ_STATUS: decode = SEL_IRQ_STATUS;
            OFS_IRQ_CLEAR: decode = SEL_IRQ_CLEAR;
            OFS_IRQ_ENABLE: decode = SEL_IRQ_ENABLE;
            default: decode = SEL_NONE;
        endcase
    endfunction

    logic aw_have_q;
    logic w_have_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [DATA_W-1:0] rdata_q;
    logic [1:0] rresp_q;
    logic wr_fire;
    logic rd_fire;
    reg_sel_type wr_sel;
    reg_sel_type rd_sel;
    logic start_q;
    logic dir_q;
    logic rx_full_q;
    logic tx_full_q;
    logic overrun_q;
    logic [BYTE_W-1:0] rx_byte_q;
    logic [BYTE_W-1:0] tx_byte_q;
    logic tx_load_q;
    logic [SLV_ADDR_W-1:0] mask_q;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_en_q;
    logic [IRQ_W-1:0] events;
    logic rx_clear;
    logic ovr_set;
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] rd_word;

    addr_cmp_if cmp_bus ();

    ////////////////////////////////////////////////////////////////////
    // Write channel: address and data may arrive in either order.
    assign o_awready = !aw_have_q && !bvalid_q;
    assign o_wready = !w_have_q && !bvalid_q;
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
    assign wr_sel = decode(awaddr_q);

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= WORD_ZERO;
            wstrb_q <= '0;
        end
        else
        begin
            if (i_awvalid && o_awready)
            begin
                aw_have_q <= 1'b1;
                awaddr_q <= i_awaddr;
            end
            else if (wr_fire)
                aw_have_q <= 1'b0;
            if (i_wvalid && o_wready)
            begin
                w_have_q <= 1'b1;
                wdata_q <= i_wdata;
                wstrb_q <= i_wstrb;
            end
            else if (wr_fire)
                w_have_q <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_q <= 1'b1;
            bresp_q <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        else if (i_bready)
            bvalid_q <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // Read channel: one outstanding read, data registered.
    assign o_arready = !rvalid_q;
    assign rd_fire = i_arvalid && o_arready;
    assign rd_sel = decode(i_araddr);

    always_comb
    begin
        status_word = WORD_ZERO;
        status_word[BIT_TX_FULL] = tx_full_q;
        status_word[BIT_RX_FULL] = rx_full_q;
        status_word[BIT_DIR] = dir_q;
        status_word[BIT_START] = start_q;
        status_word[BIT_OVERRUN] = overrun_q;
        rd_word = WORD_ZERO;
        unique case (rd_sel)
            SEL_STATUS: rd_word = status_word;
            SEL_MASK: rd_word[SLV_ADDR_W-1:0] = mask_q;
            SEL_RX_BYTE: rd_word[BYTE_W-1:0] = rx_byte_q;
            SEL_TX_BYTE: rd_word[BYTE_W-1:0] = tx_byte_q;
            SEL_IRQ_STATUS: rd_word[IRQ_W-1:0] = irq_stat_q;
            SEL_IRQ_ENABLE: rd_word[IRQ_W-1:0] = irq_en_q;
            SEL_IRQ_CLEAR: rd_word = WORD_ZERO;
            SEL_NONE: rd_word = WORD_ZERO;
        endcase
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= WORD_ZERO;
            rresp_q <= RESP_OKAY;
        end
        else if (rd_fire)
        begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        else if (i_rready)
            rvalid_q <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // Bus condition and direction flags, owned by hardware only.
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
            start_q <= 1'b0;
        else if (i_start_det)
            start_q <= 1'b1;
        else if (i_stop_det)
            start_q <= 1'b0;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
            dir_q <= 1'b0;
        else if (i_addr_done)
            dir_q <= i_addr_rw;
    end

    ////////////////////////////////////////////////////////////////////
    // Receive side.  A byte that arrives while the register is still
    // full is dropped so software keeps the older, unread byte.  A byte
    // that arrives in the cycle the old one is read takes its place, so
    // software never sees a byte twice.
    assign rx_clear = rd_fire && (rd_sel == SEL_RX_BYTE);
    assign ovr_set = i_rx_valid && rx_full_q && !rx_clear;

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            rx_full_q <= 1'b0;
            rx_byte_q <= BYTE_RESET;
        end
        else if (i_rx_valid && (!rx_full_q || rx_clear))
        begin
            rx_full_q <= 1'b1;
            rx_byte_q <= i_rx_byte;
        end
        else if (rx_clear && !i_rx_valid)
            rx_full_q <= 1'b0;
    end

    // Overrun is the one status bit software may clear, by writing 0.
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
            overrun_q <= 1'b0;
        else if (ovr_set)
            overrun_q <= 1'b1;
        else if (wr_fire && wr_sel == SEL_STATUS && wstrb_q[0] &&
                 !wdata_q[BIT_OVERRUN])
            overrun_q <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // Transmit side.
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            tx_full_q <= 1'b0;
            tx_byte_q <= BYTE_RESET;
            tx_load_q <= 1'b0;
        end
        else
        begin
            tx_load_q <= 1'b0;
            if (wr_fire && wr_sel == SEL_TX_BYTE && wstrb_q[0])
            begin
                tx_full_q <= 1'b1;
                tx_byte_q <= wdata_q[BYTE_W-1:0];
                tx_load_q <= 1'b1;
            end
            else if (i_tx_done)
                tx_full_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Address mask; only the ten low bits exist.
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
            mask_q <= MASK_RESET;
        else if (wr_fire && wr_sel == SEL_MASK)
        begin
            if (wstrb_q[0])
                mask_q[BYTE_W-1:0] <= wdata_q[BYTE_W-1:0];
            if (wstrb_q[1])
                mask_q[SLV_ADDR_W-1:BYTE_W] <=
                    wdata_q[SLV_ADDR_W-1:BYTE_W];
        end
    end

    assign cmp_bus.own_addr = i_own_addr;
    assign cmp_bus.rx_addr = i_rx_addr;
    assign cmp_bus.mask = mask_q;

    addr_match u_addr_match (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .cmp(cmp_bus.cmp)
    );

    ////////////////////////////////////////////////////////////////////
    // Interrupts: sticky status, set wins over a clear in one cycle.
    always_comb
    begin
        events = IRQ_RESET;
        events[EV_START] = i_start_det;
        events[EV_STOP] = i_stop_det;
        events[EV_RX] = i_rx_valid;
        events[EV_TX_DONE] = i_tx_done;
        events[EV_OVERRUN] = ovr_set;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
            irq_stat_q <= IRQ_RESET;
        else if (wr_fire && wr_sel == SEL_IRQ_CLEAR && wstrb_q[0])
            irq_stat_q <= (irq_stat_q & ~wdata_q[IRQ_W-1:0]) | events;
        else
            irq_stat_q <= irq_stat_q | events;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
            irq_en_q <= IRQ_RESET;
        else if (wr_fire && wr_sel == SEL_IRQ_ENABLE && wstrb_q[0])
            irq_en_q <= wdata_q[IRQ_W-1:0];
    end

    assign o_irq = |(irq_stat_q & irq_en_q);
    assign o_bvalid = bvalid_q;
    assign o_bresp = bresp_q;
    assign o_rvalid = rvalid_q;
    assign o_rdata = rdata_q;
    assign o_rresp = rresp_q;
    assign o_addr_match = cmp_bus.match;
    assign o_tx_byte = tx_byte_q;
    assign o_tx_load = tx_load_q;

    ////////////////////////////////////////////////////////////////////
    chk_start_set: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        i_start_det |=> start_q ##1 (start_q || $past(i_stop_det)))
        else $error("Start flag not set by start condition.");

    chk_stop_clear: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        i_stop_det && !i_start_det |=> !status_word[BIT_START])
        else $error("Start flag not cleared by stop.");

    chk_dir_load: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        i_addr_done |=> dir_q == $past(i_addr_rw))
        else $error("Direction flag not loaded from address byte.");

    chk_rx_set: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        i_rx_valid && !rx_full_q |=> rx_full_q &&
            rx_byte_q == $past(i_rx_byte))
        else $error("Receive-full not set on stored byte.");

    chk_rx_read: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        rx_clear && !i_rx_valid |=> !rx_full_q && o_rvalid)
        else $error("Receive read did not clear receive-full.");

    chk_tx_set: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        wr_fire && wr_sel == SEL_TX_BYTE && wstrb_q[0]
        |=> tx_full_q && o_tx_load && o_bvalid)
        else $error("Transmit write did not set transmit-full.");

    chk_tx_done: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        i_tx_done && !(wr_fire && wr_sel == SEL_TX_BYTE) |=> !tx_full_q)
        else $error("Transmit-full not cleared after shift-out.");

    chk_mask_upper: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        rd_fire && rd_sel == SEL_MASK
        |=> o_rdata[DATA_W-1:SLV_ADDR_W] == '0 &&
            o_rdata[SLV_ADDR_W-1:0] == $past(mask_q))
        else $error("Mask readback wrong or upper bits not zero.");

    chk_overrun_set: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        ovr_set |=> overrun_q && $stable(rx_byte_q))
        else $error("Overrun not flagged or old byte lost.");

    chk_status_ro: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        wr_fire && wr_sel == SEL_STATUS && !i_start_det && !i_stop_det &&
        !i_addr_done && !i_rx_valid && !i_tx_done && !rx_clear
        |=> $stable(status_word[BIT_START:BIT_TX_FULL]))
        else $error("Software write changed a read-only flag.");

endmodule

// File: i2c_node_model.sv
// Stand-in for the bus detectors and byte shifter beside the status
// block. Assumes one shared clock and one caller of send_event.
`timescale 1ns/100ps
module i2c_node_model
    import i2c_stat_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_tx_load,
    input wire logic [7:0] i_tx_gap,
    output logic o_start_det,
    output logic o_stop_det,
    output logic o_addr_done,
    output logic o_addr_rw,
    output logic o_rx_valid,
    output logic [BYTE_W-1:0] o_rx_byte,
    output logic o_tx_done
);
    int gap_q;

    initial
    begin
        {o_start_det, o_stop_det, o_addr_done, o_rx_valid} = 4'h0;
        {o_addr_rw, o_tx_done, o_rx_byte} = 10'h000;
        gap_q = 0;
    end

    ////////////////////////////////////////////////////////////////////
    // Kinds: 0 start, 1 stop, 2 address byte, 3 data byte.
    // Idle data is inverted so a stale sample cannot pass.
    task automatic send_event(input int k, input logic rw,
                              input logic [7:0] b);
        @(posedge i_ref_clk);
        o_start_det <= (k == 0);
        o_stop_det <= (k == 1);
        o_addr_done <= (k == 2);
        o_rx_valid <= (k == 3);
        o_addr_rw <= rw;
        o_rx_byte <= b;
        @(posedge i_ref_clk);
        {o_start_det, o_stop_det, o_addr_done, o_rx_valid} <= 4'h0;
        o_addr_rw <= ~rw;
        o_rx_byte <= ~b;
    endtask

    ////////////////////////////////////////////////////////////////////
    // A slow gap keeps the byte in flight long enough to see it busy.
    always @(posedge i_ref_clk)
    begin
        o_tx_done <= 1'b0;
        if (i_tx_load)
            gap_q <= int'(i_tx_gap) + 1;
        else if (gap_q == 1)
        begin
            gap_q <= 0;
            o_tx_done <= 1'b1;
        end
        else if (gap_q > 1)
            gap_q <= gap_q - 1;
    end
endmodule

// File: i2c_stat_mask_tb.sv
// Self-checking bench for the status flags and address mask block.
// Assumes i2c_node_model supplies the bus events and byte completion.
`timescale 1ns/100ps
module i2c_stat_mask_tb
    import i2c_stat_pkg::*;
    ;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [ADDR_W-1:0] awaddr = 8'h00, araddr = 8'h00;
    logic [DATA_W-1:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'hf;
    logic [SLV_ADDR_W-1:0] own_addr = 10'h2a5, rx_addr = 10'h000;
    logic [7:0] tx_gap = 8'h00;
    logic awready, wready, bvalid, arready, rvalid, addr_match;
    logic tx_load, irq, ev_start, ev_stop, ev_addr, ev_rw, ev_rx, ev_done;
    logic [1:0] bresp, rresp, last_resp;
    logic [DATA_W-1:0] rdata, last_data;
    logic [BYTE_W-1:0] tx_byte, ev_byte;
    int checks = 0;
    int n_mismatch = 0;
    int cyc = 0;

    always #2.5 ref_clk = ~ref_clk;

    i2c_stat_mask dut (.i_ref_clk(ref_clk), .i_rst_b(rst_b),
        .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
        .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
        .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready),
        .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
        .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
        .o_rdata(rdata), .o_rresp(rresp), .i_start_det(ev_start),
        .i_stop_det(ev_stop), .i_addr_done(ev_addr), .i_addr_rw(ev_rw),
        .i_rx_valid(ev_rx), .i_rx_byte(ev_byte), .i_tx_done(ev_done),
        .i_own_addr(own_addr), .i_rx_addr(rx_addr),
        .o_addr_match(addr_match), .o_tx_byte(tx_byte),
        .o_tx_load(tx_load), .o_irq(irq));

    i2c_node_model node (.i_ref_clk(ref_clk), .i_tx_load(tx_load),
        .i_tx_gap(tx_gap), .o_start_det(ev_start), .o_stop_det(ev_stop),
        .o_addr_done(ev_addr), .o_addr_rw(ev_rw), .o_rx_valid(ev_rx),
        .o_rx_byte(ev_byte), .o_tx_done(ev_done));

    ////////////////////////////////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] st(input logic s, d, r, t, o);
        st = 32'h0000_0000;
        st[BIT_START] = s;
        st[BIT_DIR] = d;
        st[BIT_RX_FULL] = r;
        st[BIT_TX_FULL] = t;
        st[BIT_OVERRUN] = o;
    endfunction

    // Results start unknown so a missing answer can never match.
    task axi_write(input logic [7:0] a, input logic [31:0] d);
        last_resp = 2'bxx;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        forever
        begin
            @(posedge ref_clk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid)
            begin
                last_resp = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask

    task axi_read(input logic [7:0] a);
        {last_resp, last_data} = 'x;
        @(posedge ref_clk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        forever
        begin
            @(posedge ref_clk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid)
            begin
                {last_resp, last_data} = {rresp, rdata};
                rready <= 1'b0;
                break;
            end
        end
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] e);
        axi_read(a);
        check(last_data, e);
    endtask

    ////////////////////////////////////////////////////////////////////
    task t_reset();
        rd_chk(OFS_BUS_STATUS, WORD_ZERO);
        rd_chk(OFS_ADDR_MASK, WORD_ZERO);
        axi_read(8'h1c);
        check(32'(last_resp), 32'(RESP_SLVERR));
        axi_write(8'h20, 32'hffff_ffff);
        check(32'(last_resp), 32'(RESP_SLVERR));
        $display("reset test ended");
    endtask

    task t_mask();
        logic [9:0] mk [6] = '{10'h000, 10'h000, 10'h001, 10'h001,
                               10'h200, 10'h3ff};
        logic [9:0] ra [6] = '{10'h2a5, 10'h2a4, 10'h2a4, 10'h2a7,
                               10'h0a5, 10'h15a};
        logic ex [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
        axi_write(OFS_ADDR_MASK, 32'hffff_ffff);
        rd_chk(OFS_ADDR_MASK, 32'h0000_03ff);
        for (int i = 0; i < 6; i++)
        begin
            axi_write(OFS_ADDR_MASK, {22'h00_0000, mk[i]});
            rx_addr <= ra[i];
            repeat (2) @(posedge ref_clk);
            #1;
            check(32'(addr_match), 32'(ex[i]));
        end
        $display("mask test ended");
    endtask

    task t_flags();
        node.send_event(0, 1'b0, 8'h00);
        rd_chk(OFS_BUS_STATUS, st(1, 0, 0, 0, 0));
        node.send_event(2, 1'b1, 8'h00);
        rd_chk(OFS_BUS_STATUS, st(1, 1, 0, 0, 0));
        axi_write(OFS_BUS_STATUS, 32'h0000_0003);
        rd_chk(OFS_BUS_STATUS, st(1, 1, 0, 0, 0));
        node.send_event(1, 1'b0, 8'h00);
        rd_chk(OFS_BUS_STATUS, st(0, 1, 0, 0, 0));
        node.send_event(0, 1'b0, 8'h00);
        node.send_event(0, 1'b0, 8'h00);
        node.send_event(2, 1'b0, 8'h00);
        rd_chk(OFS_BUS_STATUS, st(1, 0, 0, 0, 0));
        $display("flag test ended");
    endtask

    task t_rx();
        node.send_event(3, 1'b0, 8'h5a);
        rd_chk(OFS_BUS_STATUS, st(1, 0, 1, 0, 0));
        node.send_event(3, 1'b0, 8'hc3);
        rd_chk(OFS_BUS_STATUS, st(1, 0, 1, 0, 1));
        rd_chk(OFS_RX_BYTE, 32'h0000_005a);
        rd_chk(OFS_BUS_STATUS, st(1, 0, 0, 0, 1));
        $display("receive test ended");
    endtask

    task t_tx();
        tx_gap <= 8'h14;
        axi_write(OFS_TX_BYTE, 32'h0000_00a5);
        check({24'h00_0000, tx_byte}, 32'h0000_00a5);
        rd_chk(OFS_BUS_STATUS, st(1, 0, 0, 1, 1));
        repeat (30) @(posedge ref_clk);
        rd_chk(OFS_BUS_STATUS, st(1, 0, 0, 0, 1));
        tx_gap <= 8'h00;
        axi_write(OFS_TX_BYTE, 32'h0000_003c);
        repeat (4) @(posedge ref_clk);
        rd_chk(OFS_BUS_STATUS, st(1, 0, 0, 0, 1));
        $display("transmit test ended");
    endtask

    task t_irq();
        axi_write(OFS_IRQ_CLEAR, 32'h0000_001f);
        axi_write(OFS_IRQ_ENABLE, 32'h0000_0001 << EV_STOP);
        node.send_event(1, 1'b0, 8'h00);
        #1;
        check({31'h0000_0000, irq}, 32'h0000_0001);
        rd_chk(OFS_IRQ_STATUS, 32'h0000_0001 << EV_STOP);
        axi_write(OFS_IRQ_ENABLE, 32'h0000_0000);
        #1;
        check({31'h0000_0000, irq}, 32'h0000_0000);
        axi_write(OFS_IRQ_ENABLE, 32'h0000_0001 << EV_STOP);
        axi_write(OFS_IRQ_CLEAR, 32'h0000_0001 << EV_STOP);
        #1;
        check({31'h0000_0000, irq}, 32'h0000_0000);
        rd_chk(OFS_IRQ_STATUS, WORD_ZERO);
        $display("interrupt test ended");
    endtask

    ////////////////////////////////////////////////////////////////////
    task print_verdict();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // The whole run needs well under a thousand cycles.
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            n_mismatch++;
            print_verdict();
        end
    end

    initial
    begin
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'b1;
        t_reset();
        t_mask();
        t_flags();
        t_rx();
        t_tx();
        t_irq();
        print_verdict();
    end
endmodule
